//--- ppf_mem.sv
// External memory model: latches the address, answers reads
module ppf_mem (
  // Clock
  input  wire logic       CLOCK,
  // Strobes and pins from the device
  input  wire logic       ale,
  input  wire logic       strobe_n,
  input  wire logic       rd_map,
  input  wire logic       p3_oe7,
  input  wire logic       p3_out7,
  input  wire logic [7:0] p0_oe,
  input  wire logic [7:0] p2_oe,
  input  wire logic [7:0] p2_out,
  // Pin levels back to the device
  output logic      [7:0] p0_in,
  output logic      [7:0] p2_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lo = 8'h00;    // Latched low address
  logic [7:0] hi = 8'h00;    // Latched high address
  logic [7:0] last = 8'h00;  // Last byte driven
  wire logic rd = !strobe_n || (rd_map && p3_oe7 && !p3_out7);
  wire logic       drive = rd;         // Drives only while strobed
  wire logic [7:0] data = lo ^ hi;     // Read byte from address
  // Address taken on the latch strobe; data only while strobed
  always @(posedge CLOCK) begin
    if (ale) begin
      lo <= ~p0_oe;
      hi <= ~p2_oe | p2_out;
    end else if (rd) begin
      last <= data;
    end
  end
  // No pullup on port 0: released lines show the inverse
  assign p0_in = ~p0_oe & (drive ? data : ~last);
  // Port 2 released lines float high
  assign p2_in = (p2_oe & p2_out) | (~p2_oe & (drive ? data : 8'hFF));
endmodule

//--- ppf_pkg.sv
// Shared constants and types for the port pin function block
package ppf_pkg;
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned RST_HOLD_OSC   = 64;  // reset pin high, oscillator periods
  localparam int unsigned RST_HOLD_CYC   = RST_HOLD_OSC;
  localparam logic [6:0]  RST_CNT_MAX    = 7'h40;
  localparam logic [7:0]  PORT_RESET_VAL = 8'hFF;
  localparam logic [17:0] ONCHIP_LIMIT   = 18'h0_4000; // on-chip code size
  // Read-map selector codes (user_config_byte0 bits)
  localparam logic [1:0]  MAP_A16_FULL   = 2'h0; // pin carries addr_bit16
  localparam logic [1:0]  MAP_A16_HALF   = 2'h1; // pin carries addr_bit16
  localparam logic [1:0]  MAP_RD_LOW     = 2'h2; // data read strobe
  localparam logic [1:0]  MAP_RD_COMPAT  = 2'h3; // data read strobe
  // Bit positions inside port 1 and port 3
  localparam int unsigned P1_CA_CLK      = 2;
  localparam int unsigned P1_CA_BASE     = 3;
  localparam int unsigned P3_RXD         = 0;
  localparam int unsigned P3_IRQ0        = 2;
  localparam int unsigned P3_RD          = 7;
  // Bus sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } ppf_bus_state_t;
endpackage

//--- ppf_sync.sv
// Two-flop synchroniser bank for the incoming pin levels of ports 0 to 3
module ppf_sync (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // Pin levels
  ppf_sync_if.dst  s
);
  logic [31:0] stage1;  // first flop, read only by the second
  logic [31:0] stage2;  // second flop
  // Per-bit two-flop chain
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_bit
      always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          stage1[g] <= 1'b1;
          stage2[g] <= 1'b1;
        end else begin
          stage1[g] <= s.raw[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate
  assign s.sync = stage2;
endmodule

//--- ppf_sync_if.sv
// Interface carrying raw and synchronised pin levels
interface ppf_sync_if;
  logic [31:0] raw;   // raw pin levels
  logic [31:0] sync;  // levels after two flops
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface

//--- ppf_top.sv
// Port pin function control: strap, reset, bus pins, irq and alt functions
module ppf_top (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  // Reset pin and strap
  input  wire logic        RST_PIN,
  input  wire logic        EXT_CODE_ACCESS_N,
  // Configuration
  input  wire logic [1:0]  READ_MAP_SEL,
  input  wire logic        PAGE_MODE,
  input  wire logic [1:0]  IRQ_EDGE_SELECT,
  input  wire logic [1:0]  IRQ_FLAG_CLR,
  input  wire logic [4:0]  CA_OUT_MODE,
  input  wire logic [4:0]  CA_OUT_VAL,
  input  wire logic        SERIAL_MODE0,
  input  wire logic        SERIAL_RX_OUT,
  input  wire logic        LOW_POWER,
  // Bus request
  input  wire logic        BUS_REQ,
  input  wire logic        BUS_CODE,
  input  wire logic        BUS_WRITE,
  input  wire logic [17:0] BUS_ADDR,
  input  wire logic [7:0]  BUS_WDATA,
  // Port latches
  input  wire logic [7:0]  PORT0_LATCH,
  input  wire logic [7:0]  PORT1_LATCH,
  input  wire logic [7:0]  PORT2_LATCH,
  input  wire logic [7:0]  PORT3_LATCH,
  // Pins in
  input  wire logic [7:0]  PORT0_IN,
  input  wire logic [7:0]  PORT1_IN,
  input  wire logic [7:0]  PORT2_IN,
  input  wire logic [7:0]  PORT3_IN,
  // Pins out
  output logic [7:0]       PORT0_OUT,
  output logic [7:0]       PORT0_OE,
  output logic [7:0]       PORT1_OUT,
  output logic [7:0]       PORT1_OE,
  output logic [7:0]       PORT2_OUT,
  output logic [7:0]       PORT2_OE,
  output logic [7:0]       PORT3_OUT,
  output logic [7:0]       PORT3_OE,
  output logic             CODE_READ_STROBE_N,
  output logic             ADDR_LATCH,
  // Status
  output logic             CHIP_RESET,
  output logic             FETCH_ONCHIP,
  output logic             STRAP_HELD,
  output logic [1:0]       EXT_IRQ_FLAG,
  output logic [15:0]      COUNTER_ARRAY_COUNT,
  output logic [7:0]       BUS_RDATA,
  output logic             BUS_DONE
);
  // Synchronised pins
  ppf_sync_if sif ();
  logic       strap_sync;   // strap after two flops
  logic       rst_sync;     // reset pin after two flops
  logic [1:0] ctl1, ctl2;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctl1 <= 2'h3;
      ctl2 <= 2'h3;
    end else begin
      ctl1 <= {EXT_CODE_ACCESS_N, RST_PIN};
      ctl2 <= ctl1;
    end
  end
  assign strap_sync = ctl2[1];
  assign rst_sync   = ctl2[0];
  assign sif.raw = {PORT3_IN, PORT2_IN, PORT1_IN, PORT0_IN};
  ppf_sync u_sync (
    .CLOCK (CLOCK),
    .RSTN  (RSTN),
    .s     (sif.dst)
  );
  wire [7:0] p0_s = sif.sync[7:0];
  wire [7:0] p1_s = sif.sync[15:8];
  wire [7:0] p2_s = sif.sync[23:16];
  wire [7:0] p3_s = sif.sync[31:24];

  // Reset pin hold counter
  logic [6:0] rst_cnt;
  logic       chip_rst;
  wire        rst_done = (rst_cnt == ppf_pkg::RST_CNT_MAX);
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rst_cnt  <= 7'h00;
      chip_rst <= 1'b1;
    end else if (!rst_sync) begin
      rst_cnt  <= 7'h00;
      chip_rst <= 1'b0;
    end else if (!rst_done) begin
      rst_cnt  <= rst_cnt + 7'h01;
    end else begin
      chip_rst <= 1'b1;  // held 64 periods also wakes
    end
  end
  // Level gate forces pins without waiting for the count
  wire force_pins = chip_rst | rst_sync | !RSTN;

  // Strap capture on leaving reset, low-power latch
  logic strap;
  logic sleep;  // Idle or power-down, bus cycles held off
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      strap      <= 1'b0;
      sleep      <= 1'b0;
    end else begin
      sleep      <= !chip_rst & (sleep | LOW_POWER);  // Reset wakes
      if (chip_rst) begin
        strap <= strap_sync;
      end
    end
  end

  // Fetch routing
  wire in_range   = (BUS_ADDR < ppf_pkg::ONCHIP_LIMIT);
  wire onchip     = strap & in_range;
  logic [2:0] rd_pipe;  // Data phase age, covers the pin synchroniser
  wire ext_cycle  = BUS_REQ & !(BUS_CODE & onchip) & !chip_rst & !sleep
                  & !(|rd_pipe);  // One cycle at a time
  // Code strobe region chosen by map selector
  wire code_reg   = (READ_MAP_SEL == ppf_pkg::MAP_RD_COMPAT) ? BUS_CODE
                  : (BUS_CODE | !BUS_WRITE);
  wire rd_is_a16  = !READ_MAP_SEL[1];
  wire data_rd    = !BUS_CODE & !BUS_WRITE & !rd_is_a16;

  // Bus sequencer
  ppf_pkg::ppf_bus_state_t st, next_st;
  always_comb begin
    case (st)
      ppf_pkg::ST_IDLE: next_st = ext_cycle ? ppf_pkg::ST_ADDR
                                            : ppf_pkg::ST_IDLE;
      ppf_pkg::ST_ADDR: next_st = ppf_pkg::ST_DATA;
      ppf_pkg::ST_DATA: next_st = ppf_pkg::ST_IDLE;
      default:          next_st = ppf_pkg::ST_IDLE;
    endcase
  end
  logic [17:0] addr;
  logic [7:0]  wdata;
  logic        cyc_code, cyc_wr, cyc_rd, cyc_code_read_strobe_n, cyc_page;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      st <= ppf_pkg::ST_IDLE;
    end else if (force_pins) begin
      st <= ppf_pkg::ST_IDLE;
    end else begin
      st <= next_st;
    end
  end
  // Latch request at cycle start
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      addr     <= 18'h0_0000;
      wdata    <= 8'h00;
      {cyc_code, cyc_wr, cyc_rd, cyc_code_read_strobe_n, cyc_page} <= 5'h00;
    end else if (st == ppf_pkg::ST_IDLE && ext_cycle) begin
      addr     <= BUS_ADDR;
      wdata    <= BUS_WDATA;
      cyc_code <= BUS_CODE;
      cyc_wr   <= BUS_WRITE;
      cyc_rd   <= data_rd;
      cyc_code_read_strobe_n <= code_reg & !BUS_WRITE;
      cyc_page <= PAGE_MODE;
    end
  end
  wire in_addr = (st == ppf_pkg::ST_ADDR);
  wire in_data = (st == ppf_pkg::ST_DATA);
  wire data_drv = in_data & cyc_wr;

  // Bus-owned pin values
  wire [7:0] bus_p0 = (cyc_page | in_addr) ? addr[7:0] : wdata;
  wire [7:0] bus_p2 = (cyc_page & in_data) ? wdata : addr[15:8];
  wire       bus_on = in_addr | in_data;
  wire       p0_oe_bus = cyc_page ? 1'b1 : (in_addr | data_drv);
  wire       p2_oe_bus = cyc_page ? (in_addr | data_drv | !in_data) : 1'b1;

  // Alternate functions on ports 1 and 3
  logic [7:0] p1_out_n, p1_oe_n, p3_out_n, p3_oe_n;
  always_comb begin
    p1_out_n = PORT1_LATCH;
    p1_oe_n  = 8'hFF;
    p3_out_n = PORT3_LATCH;
    p3_oe_n  = 8'hFF;
    for (int i = 0; i < 5; i++) begin
      if (CA_OUT_MODE[i]) begin
        p1_out_n[ppf_pkg::P1_CA_BASE + i] = CA_OUT_VAL[i];
      end else begin
        p1_oe_n[ppf_pkg::P1_CA_BASE + i] = 1'b0;
      end
    end
    p1_oe_n[ppf_pkg::P1_CA_CLK] = 1'b0;  // Clock input pin
    p3_oe_n[ppf_pkg::P3_IRQ0]   = 1'b0;  // Irq inputs
    p3_oe_n[ppf_pkg::P3_IRQ0+1] = 1'b0;
    if (SERIAL_MODE0) begin
      p3_out_n[ppf_pkg::P3_RXD] = SERIAL_RX_OUT;
    end else begin
      p3_oe_n[ppf_pkg::P3_RXD]  = 1'b0;
    end
    if (bus_on) begin
      p3_out_n[ppf_pkg::P3_RD] = rd_is_a16 ? addr[16]
                               : !(cyc_rd & in_data);
    end
  end

  // Open drain enable: drive low where value bit is zero
  wire [7:0] next_p0_oe = bus_on ? ({8{p0_oe_bus}} & ~bus_p0)
                                 : ~PORT0_LATCH;
  // Pin output registers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      PORT0_OUT <= 8'h00;
      PORT0_OE  <= 8'h00;
      PORT1_OUT <= ppf_pkg::PORT_RESET_VAL;
      PORT1_OE  <= 8'h00;
      PORT2_OUT <= ppf_pkg::PORT_RESET_VAL;
      PORT2_OE  <= 8'h00;
      PORT3_OUT <= ppf_pkg::PORT_RESET_VAL;
      PORT3_OE  <= 8'h00;
      CODE_READ_STROBE_N <= 1'b1;
      ADDR_LATCH <= 1'b0;
    end else if (force_pins) begin
      PORT0_OUT <= 8'h00;  // Open drain: released, never high
      PORT0_OE  <= 8'h00;
      PORT1_OUT <= ppf_pkg::PORT_RESET_VAL;
      PORT1_OE  <= 8'h00;
      PORT2_OUT <= ppf_pkg::PORT_RESET_VAL;
      PORT2_OE  <= 8'h00;
      PORT3_OUT <= ppf_pkg::PORT_RESET_VAL;
      PORT3_OE  <= 8'h00;
      CODE_READ_STROBE_N <= 1'b1;
      ADDR_LATCH <= 1'b0;
    end else begin
      // Port 0 only pulls low: open drain
      PORT0_OUT <= 8'h00;
      PORT0_OE  <= next_p0_oe;
      PORT1_OUT <= p1_out_n;
      PORT1_OE  <= p1_oe_n;
      PORT2_OUT <= bus_on ? bus_p2 : PORT2_LATCH;
      PORT2_OE  <= bus_on ? {8{p2_oe_bus}} : 8'hFF;
      PORT3_OUT <= p3_out_n;
      PORT3_OE  <= p3_oe_n;
      CODE_READ_STROBE_N <= !(in_data & cyc_code_read_strobe_n);
      ADDR_LATCH <= in_addr;  // High while address stands
    end
  end

  // External interrupt flags
  logic [1:0] irq_prev;
  logic [1:0] irq_flag;
  wire  [1:0] irq_pin  = p3_s[ppf_pkg::P3_IRQ0 +: 2];
  wire  [1:0] irq_set  = (IRQ_EDGE_SELECT & irq_prev & ~irq_pin)
                       | (~IRQ_EDGE_SELECT & ~irq_pin);
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      irq_prev <= 2'h3;
      irq_flag <= 2'h0;
    end else if (chip_rst) begin
      irq_prev <= 2'h3;
      irq_flag <= 2'h0;
    end else begin
      irq_prev <= irq_pin;
      irq_flag <= irq_set | (irq_flag & ~IRQ_FLAG_CLR);  // set wins
    end
  end

  // Counter clock input edge count
  logic        ca_prev;
  logic [15:0] ca_count;
  wire         ca_pin = p1_s[ppf_pkg::P1_CA_CLK];
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ca_prev  <= 1'b1;
      ca_count <= 16'h0000;
    end else if (chip_rst) begin
      ca_prev  <= 1'b1;
      ca_count <= 16'h0000;
    end else begin
      ca_prev <= ca_pin;
      if (ca_prev & !ca_pin) begin
        ca_count <= ca_count + 16'h0001;
      end
    end
  end

  // Status and read data registers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      CHIP_RESET   <= 1'b1;
      FETCH_ONCHIP <= 1'b0;
      STRAP_HELD   <= 1'b0;
      EXT_IRQ_FLAG <= 2'h0;
      COUNTER_ARRAY_COUNT <= 16'h0000;
      BUS_RDATA    <= 8'h00;
      BUS_DONE     <= 1'b0;
      rd_pipe      <= 3'h0;
    end else begin
      CHIP_RESET   <= chip_rst;
      FETCH_ONCHIP <= BUS_REQ & BUS_CODE & onchip & !chip_rst;
      STRAP_HELD   <= strap;
      EXT_IRQ_FLAG <= irq_flag;
      COUNTER_ARRAY_COUNT <= ca_count;
      BUS_DONE     <= rd_pipe[2];
      rd_pipe      <= {rd_pipe[1:0], in_data};  // Wait out pin sync
      if (rd_pipe[2] & !cyc_wr) begin
        BUS_RDATA <= cyc_page ? p2_s : p0_s;
      end
    end
  end
endmodule

//--- ppf_top_sva.sv
// Checker for the port pin function block, seen from its top ports
module ppf_top_sva (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RSTN,
  // Inputs watched
  input wire logic        RST_PIN,
  input wire logic [1:0]  READ_MAP_SEL,
  input wire logic [4:0]  CA_OUT_MODE,
  input wire logic        BUS_CODE,
  input wire logic [17:0] BUS_ADDR,
  // Outputs watched
  input wire logic [7:0]  PORT0_OUT,
  input wire logic [7:0]  PORT0_OE,
  input wire logic [7:0]  PORT1_OE,
  input wire logic [7:0]  PORT2_OUT,
  input wire logic [7:0]  PORT3_OUT,
  input wire logic [7:0]  PORT3_OE,
  input wire logic        CODE_READ_STROBE_N,
  input wire logic        ADDR_LATCH,
  input wire logic        CHIP_RESET,
  input wire logic        FETCH_ONCHIP,
  input wire logic        STRAP_HELD,
  input wire logic        BUS_DONE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  logic [6:0] hi_cnt;  // Cycles the reset pin stayed high
  // Saturating count of reset pin high time
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) hi_cnt <= 7'h00;
    else if (!RST_PIN) hi_cnt <= 7'h00;
    else if (hi_cnt != 7'h7F) hi_cnt <= hi_cnt + 7'h01;
  end
  // Start and steps of one external bus cycle
  sequence s_start;
    $rose(ADDR_LATCH);
  endsequence
  sequence s_cycle;
    ADDR_LATCH ##1 !ADDR_LATCH ##3 BUS_DONE;
  endsequence
  AST_P0_OPEN_DRAIN: assert property (PORT0_OUT == 8'h00)
    else $error("port 0 drives a high level");
  AST_PIN_FORCE: assert property (RST_PIN [*4] |->
    PORT1_OE == 8'h00 && PORT3_OE == 8'h00)
    else $error("pins not forced while reset pin high");
  AST_RST_MIN: assert property ($rose(CHIP_RESET) |-> hi_cnt >= 7'd64)
    else $error("chip reset after too short a pulse");
  AST_RST_MAX: assert property (hi_cnt == 7'd69 |-> CHIP_RESET)
    else $error("chip reset missing after long pulse");
  AST_STRAP_HOLD: assert property (!CHIP_RESET && !$past(CHIP_RESET)
    |-> $stable(STRAP_HELD))
    else $error("strap changed outside reset");
  AST_STRAP_LOW: assert property (!STRAP_HELD && !$past(STRAP_HELD)
    |-> !FETCH_ONCHIP)
    else $error("on-chip fetch with strap low");
  AST_BUS_CYCLE: assert property (s_start |-> s_cycle)
    else $error("latch pulse or completion out of step");
  AST_CODE_ONLY: assert property (READ_MAP_SEL == 2'h3 && !BUS_CODE
    && $rose(ADDR_LATCH) |-> CODE_READ_STROBE_N [*3])
    else $error("code strobe on a data read");
  AST_BIT16: assert property (!READ_MAP_SEL[1] && $rose(ADDR_LATCH)
    |-> PORT3_OUT[7] == BUS_ADDR[16])
    else $error("shared pin lacks address bit 16");
  AST_ADDR_PINS: assert property ($rose(ADDR_LATCH) |->
    PORT2_OUT == BUS_ADDR[15:8] && PORT0_OE == ~BUS_ADDR[7:0])
    else $error("address bytes wrong on ports");
  AST_CAPTURE_IN: assert property ((PORT1_OE[6:3] & ~CA_OUT_MODE[3:0]
    & ~$past(CA_OUT_MODE[3:0])) == 4'h0)
    else $error("capture pin driven");
endmodule

bind ppf_top ppf_top_sva chk (
  .CLOCK, .RSTN, .RST_PIN, .READ_MAP_SEL, .CA_OUT_MODE, .BUS_CODE,
  .BUS_ADDR, .PORT0_OUT, .PORT0_OE, .PORT1_OE, .PORT2_OUT, .PORT3_OUT,
  .PORT3_OE, .CODE_READ_STROBE_N, .ADDR_LATCH, .CHIP_RESET,
  .FETCH_ONCHIP, .STRAP_HELD, .BUS_DONE
);

//--- ppf_top_test.sv
// Testbench for the port pin function block
module ppf_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and strap
  logic CLOCK = 1'b0, RSTN = 1'b0, RST_PIN = 1'b1, EXT_CODE_ACCESS_N = 1'b1;
  // Configuration
  logic [1:0] READ_MAP_SEL = 2'h0, IRQ_EDGE_SELECT = 2'h0;
  logic [1:0] IRQ_FLAG_CLR = 2'h0;
  logic       PAGE_MODE = 1'b0, SERIAL_MODE0 = 1'b0, LOW_POWER = 1'b0;
  logic [4:0] CA_OUT_MODE = 5'h00;
  // Bus request
  logic        BUS_REQ = 1'b0, BUS_CODE = 1'b0;
  logic [17:0] BUS_ADDR = 18'h0_0000;
  // Latches and board pin levels
  logic [7:0] lat0 = 8'hFF, lat13 = 8'hFF, lat2 = 8'hFF;
  logic [7:0] ext1 = 8'hFF, ext3 = 8'hFF;
  wire logic [7:0] PORT0_IN, PORT1_IN, PORT2_IN, PORT3_IN;
  // Design outputs
  logic [7:0]  PORT0_OUT, PORT0_OE, PORT1_OUT, PORT1_OE;
  logic [7:0]  PORT2_OUT, PORT2_OE, PORT3_OUT, PORT3_OE, BUS_RDATA;
  logic        CODE_READ_STROBE_N, ADDR_LATCH, CHIP_RESET, BUS_DONE;
  logic        FETCH_ONCHIP, STRAP_HELD;
  logic [1:0]  EXT_IRQ_FLAG;
  logic [15:0] COUNTER_ARRAY_COUNT, q16;
  logic [17:0] a;
  logic [3:0]  m;
  int n_errors = 0, check_count = 0, cyc = 0, n_ale = 0, ale0 = 0;
  // Pullup ports: a low latch pulls the line down
  assign PORT1_IN = ext1 & ~(PORT1_OE & ~PORT1_OUT);
  assign PORT3_IN = ext3 & ~(PORT3_OE & ~PORT3_OUT);
  ppf_top dut (.CLOCK, .RSTN, .RST_PIN, .EXT_CODE_ACCESS_N, .READ_MAP_SEL,
    .PAGE_MODE, .IRQ_EDGE_SELECT, .IRQ_FLAG_CLR, .CA_OUT_MODE,
    .CA_OUT_VAL(5'h0A), .SERIAL_MODE0, .SERIAL_RX_OUT(1'b0),
    .LOW_POWER, .BUS_REQ, .BUS_CODE, .BUS_WRITE(1'b0), .BUS_ADDR,
    .BUS_WDATA(lat2), .PORT0_LATCH(lat0), .PORT1_LATCH(lat13),
    .PORT2_LATCH(lat2), .PORT3_LATCH(lat13), .PORT0_IN, .PORT1_IN,
    .PORT2_IN, .PORT3_IN, .PORT0_OUT, .PORT0_OE, .PORT1_OUT, .PORT1_OE,
    .PORT2_OUT, .PORT2_OE, .PORT3_OUT, .PORT3_OE, .CODE_READ_STROBE_N,
    .ADDR_LATCH, .CHIP_RESET, .FETCH_ONCHIP, .STRAP_HELD, .EXT_IRQ_FLAG,
    .COUNTER_ARRAY_COUNT, .BUS_RDATA, .BUS_DONE);
  ppf_mem mem (.CLOCK, .ale(ADDR_LATCH), .strobe_n(CODE_READ_STROBE_N),
    .rd_map(READ_MAP_SEL[1]), .p3_oe7(PORT3_OE[7]),
    .p3_out7(PORT3_OUT[7]), .p0_oe(PORT0_OE), .p2_oe(PORT2_OE),
    .p2_out(PORT2_OUT), .p0_in(PORT0_IN), .p2_in(PORT2_IN));
  // Clock and hang guard
  always #4 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cyc++;
    if (ADDR_LATCH === 1'b1) n_ale++;
    if (cyc == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  task end_sim();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  // Reset pin pulse of n cycles with a strap level
  task pin_rst(input int n, input logic s);
    EXT_CODE_ACCESS_N = s;
    RST_PIN = 1'b1;
    wt(n);
    RST_PIN = 1'b0;
    wt(6);
  endtask
  // One fetch or read; on-chip ones must stay off the bus
  task rd(input logic c, input logic [17:0] ad, input logic on,
          input logic [7:0] e);
    logic d, f;
    logic [7:0] q;
    d = 1'b0;
    f = 1'b0;
    q = 8'h00;
    BUS_CODE = c;
    BUS_ADDR = ad;
    BUS_REQ = 1'b1;
    for (int i = 0; i < 8 && !d; i++) begin
      @(posedge CLOCK);
      #1;
      d = (BUS_DONE === 1'b1);
      f = f | (FETCH_ONCHIP === 1'b1);
      q = BUS_RDATA;
    end
    @(negedge CLOCK);
    BUS_REQ = 1'b0;
    chk({14'h0, d, f}, {14'h0, !on, on});
    if (!on) chk({8'h00, q}, {8'h00, e});
    wt(2);
  endtask
  initial begin
    wt(8);
    RSTN = 1'b1;
    wt(70);
    chk({15'h0, CHIP_RESET}, 16'h0001);
    chk({PORT1_OE, PORT1_OUT}, 16'h00FF);
    RST_PIN = 1'b0;
    wt(6);
    EXT_CODE_ACCESS_N = 1'b0;
    wt(4);
    chk({15'h0, STRAP_HELD}, 16'h0001);
    EXT_CODE_ACCESS_N = 1'b1;
    RST_PIN = 1'b1;
    wt(20);
    chk({CHIP_RESET, 7'h00, PORT3_OE}, 16'h0000);
    RST_PIN = 1'b0;
    lat0 = 8'h3C;
    lat2 = 8'hA5;
    wt(6);
    chk({PORT0_OE, PORT2_OUT}, 16'hC3A5);
    lat0 = 8'hFF;
    wt(2);
    rd(1'b1, 18'h0_0100, 1'b1, 8'h00);
    rd(1'b1, 18'h0_3FFF, 1'b1, 8'h00);
    rd(1'b1, 18'h0_4000, 1'b0, 8'h40);
    for (int k = 0; k < 16; k++) begin
      m = k[3:0];
      READ_MAP_SEL = m[1:0];
      PAGE_MODE = m[2];
      a = {m[0], 1'b0, 4'h9, m, m, 4'h5};
      wt(1);
      rd(m[3], a, 1'b0, {4'h9, m} ^ {m, 4'h5});
    end
    // Low power holds off bus cycles until a chip reset
    LOW_POWER = 1'b1;
    wt(1);
    LOW_POWER = 1'b0;
    ale0 = n_ale;
    BUS_CODE = 1'b1;
    BUS_ADDR = 18'h0_4000;
    BUS_REQ = 1'b1;
    wt(8);
    BUS_REQ = 1'b0;
    chk(16'(n_ale - ale0), 16'h0000);
    pin_rst(70, 1'b0);
    chk({15'h0, STRAP_HELD}, 16'h0000);
    rd(1'b1, 18'h0_0100, 1'b0, 8'h01);
    ext3[3:2] = 2'b00;
    wt(6);
    IRQ_FLAG_CLR = 2'h3;
    wt(1);
    IRQ_FLAG_CLR = 2'h0;
    wt(6);
    chk({14'h0, EXT_IRQ_FLAG}, 16'h0003);
    IRQ_EDGE_SELECT = 2'h3;
    IRQ_FLAG_CLR = 2'h3;
    wt(1);
    IRQ_FLAG_CLR = 2'h0;
    wt(6);
    chk({14'h0, EXT_IRQ_FLAG}, 16'h0000);
    ext3[3:2] = 2'b11;
    wt(6);
    ext3[3:2] = 2'b00;
    wt(6);
    chk({14'h0, EXT_IRQ_FLAG}, 16'h0003);
    q16 = COUNTER_ARRAY_COUNT;
    repeat (10) begin
      ext1[2] = 1'b0;
      wt(4);
      ext1[2] = 1'b1;
      wt(4);
    end
    chk(COUNTER_ARRAY_COUNT, q16 + 16'h000A);
    CA_OUT_MODE = 5'h05;
    SERIAL_MODE0 = 1'b1;
    wt(6);
    chk({9'h000, PORT1_OE[5:3], PORT1_OUT[5], PORT1_OUT[3], PORT3_OE[0],
         PORT3_OUT[0]}, 16'h0052);
    SERIAL_MODE0 = 1'b0;
    wt(6);
    chk({15'h0, PORT3_OE[0]}, 16'h0000);
    end_sim();
  end
endmodule
